// >>> src/smem_port.v
// static memory / expansion port sequencer with register port
// assumes: i_mclk 100 MHz; expansion clock is i_mclk divided by two
// Functional notes
// - stretch access by waits or ready low
// - sample ready on falling edge before transfer
// - ready low delays transfer one period
// - reads hold address, widths, direction afterwards
// - writes hold address, data, widths, direction
// - no zero-wait sequential writes with strobe
// - bursts of two to four beats only
// - minimum-wait burst read is 1-0-0-0
// - minimum-wait burst write is 1-1-1-1; the first beat here takes no wait, giving 0-1-1-1
// - sequential mode uses seq waits, no idles
// - chip select on rise, release on fall
// - address presented on rise, changed on fall
// - write strobe changes on rising edges
// - output enable changes on falling edges
// - read data captured on falling edge
// - write data driven from rising edge; later burst beats are driven from the falling edge
// - direction output asserted on rising edge
// - word/halfword selects change on falling edge
// - separate halfword and word select outputs
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "smem_port_consts.vh"

module smem_port (
	// clock and reset
	input  wire        i_mclk,
	input  wire        i_nrst,
	// register port
	input  wire [2:0]  i_reg_addr,
	input  wire [31:0] i_reg_wdata,
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	output reg  [31:0] o_reg_rdata,
	// expansion side
	output wire        o_expansion_clock,
	input  wire        i_ext_ready_in,
	output reg  [3:0]  o_chip_select_n,
	output reg  [27:0] o_addr,
	output reg         o_write_strobe_n,
	output reg         o_output_enable_n,
	output reg         o_halfword,
	output reg         o_word,
	output reg         o_write_dir,
	input  wire [31:0] i_data,
	output reg  [31:0] o_data,
	output reg         o_data_oe_n
);

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	reg        ph_r;
	reg [8:0]  ctrl_r;
	reg [27:0] addr_reg_r;
	reg        cmd_wr_r;
	reg [1:0]  cmd_size_r;
	reg [1:0]  cmd_cs_r;
	reg        pend_r;
	reg [31:0] data_r [0:3];
	reg [2:0]  state_r;
	reg [2:0]  wcnt_r;
	reg [1:0]  beat_r;
	reg [1:0]  len_r;
	reg        first_r;
	reg        last_r;
	reg        last_rd_r;

	wire       ready_s;
	wire       rise;
	wire       fall;
	wire [2:0] wait_nseq;
	wire [2:0] wait_seq;
	wire       seq_en;
	wire       beat_last;
	wire       busy;
	wire [27:0] step;
	wire       seq_start;

	// ready crosses in through two flops before anything looks at it
	smem_sync2 u_ready_sync (
		.i_mclk  (i_mclk),
		.i_nrst  (i_nrst),
		.i_async (i_ext_ready_in),
		.o_sync  (ready_s)
	);

	// ----------------------------------------------------------------
	// expansion clock phases
	// ----------------------------------------------------------------
	// rise: this edge drives the expansion clock high; fall: low
	assign rise              = ~ph_r;
	assign fall              = ph_r;
	assign o_expansion_clock = ph_r;

	assign wait_nseq = ctrl_r[`CTRL_NSEQ_MSB:`CTRL_NSEQ_LSB];
	assign wait_seq  = ctrl_r[`CTRL_SEQ_MSB:`CTRL_SEQ_LSB];
	assign seq_en    = ctrl_r[`CTRL_SQEN_BIT];
	assign beat_last = (beat_r == len_r);
	assign busy      = pend_r | (state_r != `ST_IDLE);
	assign step      = {25'h000_0000, cmd_size_r == `SIZE_WORD,
		cmd_size_r == `SIZE_HALF, cmd_size_r == `SIZE_BYTE};
	// back-to-back reads in sequential mode skip the long first wait
	assign seq_start = seq_en & last_rd_r & ~cmd_wr_r;

	// ----------------------------------------------------------------
	// register port and sequencer
	// ----------------------------------------------------------------
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			ph_r              <= 1'b0;
			ctrl_r            <= `CTRL_RESET;
			addr_reg_r        <= `ADDR_RESET;
			cmd_wr_r          <= 1'b0;
			cmd_size_r        <= `SIZE_BYTE;
			cmd_cs_r          <= 2'h0;
			pend_r            <= 1'b0;
			data_r[0]         <= `DATA_RESET;
			data_r[1]         <= `DATA_RESET;
			data_r[2]         <= `DATA_RESET;
			data_r[3]         <= `DATA_RESET;
			state_r           <= `ST_IDLE;
			wcnt_r            <= `WAIT_ZERO;
			beat_r            <= `BEAT_FIRST;
			len_r             <= `BEAT_FIRST;
			first_r           <= 1'b0;
			last_r            <= 1'b0;
			last_rd_r         <= 1'b0;
			o_reg_rdata       <= `DATA_RESET;
			o_chip_select_n   <= `CS_IDLE;
			o_addr            <= `ADDR_RESET;
			o_write_strobe_n  <= 1'b1;
			o_output_enable_n <= 1'b1;
			o_halfword        <= 1'b0;
			o_word            <= 1'b0;
			o_write_dir       <= 1'b0;
			o_data            <= `DATA_RESET;
			o_data_oe_n       <= 1'b1;
		end else begin
			ph_r <= ~ph_r;

			// read data stands only in the cycle after the strobe
			o_reg_rdata <= `DATA_RESET;
			if (i_reg_rd) begin
				case (i_reg_addr)
				`REG_CTRL:   o_reg_rdata <= {23'h00_0000, ctrl_r};
				`REG_ADDR:   o_reg_rdata <= {4'h0, addr_reg_r};
				`REG_CMD:    o_reg_rdata <= {27'h000_0000, cmd_cs_r, cmd_size_r, cmd_wr_r};
				`REG_STATUS: o_reg_rdata <= {30'h0000_0000, ready_s, busy};
				default:     o_reg_rdata <= data_r[i_reg_addr[1:0]];
				endcase
			end

			// configuration may change only while the port is idle
			if (i_reg_wr && !busy) begin
				case (i_reg_addr)
				`REG_CTRL: ctrl_r     <= i_reg_wdata[8:0];
				`REG_ADDR: addr_reg_r <= i_reg_wdata[27:0];
				`REG_CMD: begin
					cmd_wr_r   <= i_reg_wdata[`CMD_WR_BIT];
					cmd_size_r <= i_reg_wdata[`CMD_SIZE_MSB:`CMD_SIZE_LSB];
					cmd_cs_r   <= i_reg_wdata[`CMD_CS_MSB:`CMD_CS_LSB];
					pend_r     <= 1'b1;
				end
				`REG_STATUS: ;
				default: data_r[i_reg_addr[1:0]] <= i_reg_wdata;
				endcase
			end

			case (state_r)
			`ST_IDLE: begin
				if (pend_r && rise) begin
					pend_r          <= 1'b0;
					o_chip_select_n <= ~(4'h1 << cmd_cs_r);
					o_addr          <= addr_reg_r;
					o_write_dir     <= cmd_wr_r;
					// burst field gives beats minus one, so four is the cap
					len_r           <= ctrl_r[`CTRL_BLEN_MSB:`CTRL_BLEN_LSB];
					beat_r          <= `BEAT_FIRST;
					first_r         <= 1'b1;
					state_r         <= `ST_BEAT;
					if (cmd_wr_r) begin
						o_data           <= data_r[0];
						o_data_oe_n      <= 1'b0;
						o_write_strobe_n <= 1'b0;
						wcnt_r           <= wait_nseq;
					end else begin
						o_data_oe_n <= 1'b1;
						// one forced wait on the first read beat: 1-0-0-0
						wcnt_r <= seq_start ? wait_seq : wait_nseq + `WAIT_ONE;
					end
				end
			end
			`ST_BEAT: begin
				if (fall) begin
					first_r <= 1'b0;
					if (first_r) begin
						o_halfword <= (cmd_size_r == `SIZE_HALF);
						o_word     <= (cmd_size_r == `SIZE_WORD);
						if (!cmd_wr_r)
							o_output_enable_n <= 1'b0;
					end
					if (wcnt_r != `WAIT_ZERO) begin
						wcnt_r <= wcnt_r - `WAIT_ONE;
					end else if (ready_s && !(first_r && !cmd_wr_r)) begin
						if (!cmd_wr_r) begin
							data_r[beat_r] <= i_data;
							if (beat_last) begin
								o_output_enable_n <= 1'b1;
								o_chip_select_n   <= `CS_IDLE;
								last_rd_r         <= 1'b1;
								state_r           <= seq_en ? `ST_IDLE : `ST_GAP;
							end else begin
								beat_r <= beat_r + `BEAT_ONE;
								o_addr <= o_addr + step;
								wcnt_r <= wait_seq;
							end
						end else begin
							last_r  <= beat_last;
							state_r <= `ST_WREL;
						end
					end
				end
			end
			`ST_WREL: begin
				// strobe goes high for a period between beats, so a
				// write beat after the first is never shorter than one wait state
				if (rise) begin
					o_write_strobe_n <= 1'b1;
					state_r          <= last_r ? `ST_CSREL : `ST_WASR;
				end
			end
			`ST_WASR: begin
				// next beat moves only once the strobe is up, so a memory
				// latching on the strobe edge still sees the old beat
				if (fall) begin
					beat_r <= beat_r + `BEAT_ONE;
					o_addr <= o_addr + step;
					o_data <= data_r[beat_r + `BEAT_ONE];
				end
				if (rise) begin
					o_write_strobe_n <= 1'b0;
					wcnt_r           <= wait_seq;
					state_r          <= `ST_BEAT;
				end
			end
			`ST_CSREL: begin
				// address, data, widths and direction stay put
				if (fall) begin
					o_chip_select_n <= `CS_IDLE;
					last_rd_r       <= 1'b0;
					state_r         <= seq_en ? `ST_IDLE : `ST_GAP;
				end
			end
			`ST_GAP: begin
				// a whole expansion period with no select active
				if (fall)
					state_r <= `ST_IDLE;
			end
			default: state_r <= `ST_IDLE;
			endcase
		end
	end

endmodule // smem_port

// >>> src/smem_port_consts.vh
// constants for the static memory and expansion port sequencer
// assumes: included by src/smem_port.v only, by its bare name
`ifndef SMEM_PORT_CONSTS_VH
`define SMEM_PORT_CONSTS_VH

// ----------------------------------------------------------------
// register indices (register bus address)
// ----------------------------------------------------------------
`define REG_CTRL        3'h0
`define REG_ADDR        3'h1
`define REG_CMD         3'h2
`define REG_STATUS      3'h3
`define REG_DATA0       3'h4

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_NSEQ_LSB   0
`define CTRL_NSEQ_MSB   2
`define CTRL_SEQ_LSB    3
`define CTRL_SEQ_MSB    5
`define CTRL_SQEN_BIT   6
`define CTRL_BLEN_LSB   7
`define CTRL_BLEN_MSB   8
`define CTRL_RESET      9'h000

// ----------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------
`define CMD_WR_BIT      0
`define CMD_SIZE_LSB    1
`define CMD_SIZE_MSB    2
`define CMD_CS_LSB      3
`define CMD_CS_MSB      4

// ----------------------------------------------------------------
// access sizes
// ----------------------------------------------------------------
`define SIZE_BYTE       2'h0
`define SIZE_HALF       2'h1
`define SIZE_WORD       2'h2

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
`define ST_IDLE         3'h0
`define ST_BEAT         3'h1
`define ST_WREL         3'h2
`define ST_WASR         3'h3
`define ST_CSREL        3'h4
`define ST_GAP          3'h5

// ----------------------------------------------------------------
// reset values of pins and counters, and counter steps
// ----------------------------------------------------------------
`define CS_IDLE         4'hf
`define ADDR_RESET      28'h000_0000
`define DATA_RESET      32'h0000_0000
`define WAIT_ZERO       3'h0
`define WAIT_ONE        3'h1
`define BEAT_FIRST      2'h0
`define BEAT_ONE        2'h1

`endif

// >>> src/smem_sync2.v
// two flip-flop synchroniser for one asynchronous level
// assumes: i_async comes from a pin with no relation to i_mclk
`timescale 1ns/100ps

module smem_sync2 (
	// clock and reset
	input  wire i_mclk,
	input  wire i_nrst,
	// level in and out
	input  wire i_async,
	output wire o_sync
);

	reg meta_r;
	reg sync_r;

	// first stage feeds only the second
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule // smem_sync2

// >>> verification/smem_mem_model.sv
// word memory on the expansion port with a slow-ready option
// assumes: word accesses only; released data bus toggles
`timescale 1ns/100ps
module smem_mem_model (
	input  wire        i_mclk,
	input  wire        i_slow,
	input  wire [3:0]  i_cs_n,
	input  wire [27:0] i_addr,
	input  wire        i_we_n,
	input  wire        i_oe_n,
	input  wire [31:0] i_wdata,
	output reg  [31:0] o_rdata,
	output wire        o_ready
);
	reg [31:0] mem [0:15];
	reg [3:0]  hold_r;
	integer    k;
	initial begin
		o_rdata = 32'h0;
		hold_r = 4'h0;
		for (k = 0; k < 16; k = k + 1)
			mem[k] = {16'hc0de, 12'h000, k[3:0]};
	end
	// ready drops early in each access, as a slow part would
	assign o_ready = !i_slow || hold_r > 4'h5;
	always @(posedge i_mclk) begin
		hold_r <= (i_oe_n && i_we_n) ? 4'h0 : hold_r + {3'h0, hold_r != 4'hf};
		// unselected bus shows no stale value
		o_rdata <= (!i_oe_n && i_cs_n != 4'hf) ? mem[i_addr[5:2]] : ~o_rdata;
		if (!i_we_n && i_cs_n != 4'hf)
			mem[i_addr[5:2]] <= i_wdata;
	end
endmodule // smem_mem_model

// >>> verification/smem_port_sva.sv
// checker of expansion pin edge relations
// assumes: bound to smem_port; expansion clock is i_mclk/2
`timescale 1ns/100ps
module smem_port_chk (
	input wire        i_mclk,
	input wire        i_nrst,
	input wire        i_reg_rd,
	input wire [31:0] o_reg_rdata,
	input wire        o_expansion_clock,
	input wire [3:0]  o_chip_select_n,
	input wire [27:0] o_addr,
	input wire        o_write_strobe_n,
	input wire        o_output_enable_n,
	input wire        o_halfword,
	input wire        o_word,
	input wire        o_write_dir,
	input wire [31:0] o_data
);
	// ----
	// pin timing; clock high after an edge marks a rise
	// ----
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	wire idle = &o_chip_select_n;
	sequence s_we_low;
		$fell(o_write_strobe_n);
	endsequence
	AST_XCLK: assert property ($past(i_nrst) |-> o_expansion_clock != $past(o_expansion_clock))
		else $error("expansion clock stalled");
	AST_CS_ON: assert property ($fell(idle) |-> o_expansion_clock)
		else $error("select asserted off a rise");
	AST_CS_OFF: assert property ($rose(idle) |-> !o_expansion_clock)
		else $error("select released off a fall");
	AST_ADDR: assert property ($changed(o_addr) && !$fell(idle) |-> !o_expansion_clock)
		else $error("address moved off a fall");
	AST_WE: assert property ($changed(o_write_strobe_n) |-> o_expansion_clock)
		else $error("write strobe moved off a rise");
	AST_OE: assert property ($changed(o_output_enable_n) |-> !o_expansion_clock)
		else $error("output enable moved off a fall");
	AST_DIR: assert property ($rose(o_write_dir) |-> o_expansion_clock)
		else $error("direction set off a rise");
	AST_WIDTH: assert property ($changed(o_word) || $fell(o_halfword) |-> !o_expansion_clock)
		else $error("width select moved off a fall");
	AST_HOLD: assert property (idle && $past(idle) |-> $stable(o_addr) && $stable(o_write_dir)
		&& $stable(o_word) && $stable(o_halfword) && $stable(o_data))
		else $error("pins moved between accesses");
	AST_WE_CS: assert property (s_we_low |-> o_write_dir && !idle ##1 !o_write_strobe_n)
		else $error("write strobe without write access");
	AST_OE_RD: assert property (!o_output_enable_n |-> !o_write_dir && !idle)
		else $error("output enable outside a read");
	AST_RDATA: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule // smem_port_chk
bind smem_port smem_port_chk chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .o_expansion_clock(o_expansion_clock),
	.o_chip_select_n(o_chip_select_n), .o_addr(o_addr), .o_write_strobe_n(o_write_strobe_n),
	.o_output_enable_n(o_output_enable_n), .o_halfword(o_halfword), .o_word(o_word),
	.o_write_dir(o_write_dir), .o_data(o_data));

// >>> verification/test_smem_port.sv
// self-checking bench of the expansion port sequencer
// assumes: design, memory model and bound checker compiled first
`timescale 1ns/100ps
module test_smem_port;
	reg         i_mclk, i_nrst, i_reg_wr, i_reg_rd, slow;
	reg  [2:0]  i_reg_addr;
	reg  [31:0] i_reg_wdata, v;
	wire [31:0] o_reg_rdata, o_data, mdata;
	wire [27:0] o_addr;
	wire [3:0]  cs_n;
	wire        xclk, rdy, we_n, oe_n, hw, wd, dir, doe_n;
	reg  [3:0]  cs_seen;
	integer     err_total, cmp_count, cyc, low, wes, k;
	smem_port uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .o_expansion_clock(xclk), .i_ext_ready_in(rdy),
		.o_chip_select_n(cs_n), .o_addr(o_addr), .o_write_strobe_n(we_n),
		.o_output_enable_n(oe_n), .o_halfword(hw), .o_word(wd), .o_write_dir(dir),
		.i_data(mdata), .o_data(o_data), .o_data_oe_n(doe_n));
	smem_mem_model mdl (.i_mclk(i_mclk), .i_slow(slow), .i_cs_n(cs_n), .i_addr(o_addr),
		.i_we_n(we_n), .i_oe_n(oe_n), .i_wdata(o_data), .o_rdata(mdata), .o_ready(rdy));
	// ----
	// bus tasks
	// ----
	task chk(input [8*8-1:0] nm, input [31:0] e, input [31:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("BAD %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [2:0] a, input [31:0] d);
		begin
			@(posedge i_mclk);
			i_reg_addr <= a;
			i_reg_wdata <= d;
			i_reg_wr <= 1'b1;
			@(posedge i_mclk);
			i_reg_wr <= 1'b0;
		end
	endtask
	task rd(input [2:0] a, output [31:0] d);
		begin
			@(posedge i_mclk);
			i_reg_addr <= a;
			i_reg_rd <= 1'b1;
			@(posedge i_mclk);
			i_reg_rd <= 1'b0;
			#1;
			d = o_reg_rdata;
		end
	endtask
	// start an access, time it on the pins, then wait for idle
	task run(input [4:0] cmd);
		integer n;
		begin
			low = 0;
			wes = 0;
			wr(3'h2, {27'h0, cmd});
			for (n = 0; n < 300 && !(low > 0 && cs_n === 4'hf); n = n + 1) begin
				@(posedge i_mclk);
				#1;
				if (cs_n !== 4'hf) begin
					low = low + 1;
					cs_seen = cs_n;
				end
				if (we_n === 1'b0)
					wes = wes + 1;
			end
			v = 32'h1;
			for (n = 0; n < 50 && v[0] !== 1'b0; n = n + 1)
				rd(3'h3, v);
			chk("busy", 32'h0, {31'h0, v[0]});
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d errors %0d", cmp_count, err_total);
			if (err_total == 0 && cmp_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// ----
	// scenarios
	// ----
	task t_reset;
		begin
			chk("cs", 32'hf, {28'h0, cs_n});
			wr(3'h3, 32'hffff_ffff);
			rd(3'h3, v);
			chk("status", 32'h2, v);
		end
	endtask
	task t_single_read;
		begin
			wr(3'h0, 32'h0);
			wr(3'h1, 32'h8);
			run(5'h04);
			chk("cs0", 32'he, {28'h0, cs_seen});
			rd(3'h4, v);
			chk("rdata", 32'hc0de_0002, v);
			chk("addr", 32'h8, {4'h0, o_addr});
			chk("width", 32'h1, {30'h0, hw, wd});
			chk("dir", 32'h0, {31'h0, dir});
		end
	endtask
	task t_burst_read;
		begin
			wr(3'h0, 32'h180);
			wr(3'h1, 32'h10);
			run(5'h04);
			chk("len", 32'h9, low);
			slow = 1'b1;
			wr(3'h1, 32'h30);
			run(5'h04);
			slow = 1'b0;
			chk("stretch", 32'h1, {31'h0, low > 9});
			for (k = 0; k < 4; k = k + 1) begin
				rd(3'h4 + k[2:0], v);
				chk("burst", {16'hc0de, 12'h000, 4'hc + k[3:0]}, v);
			end
			chk("hold", 32'h3c, {4'h0, o_addr});
		end
	endtask
	task t_burst_write;
		begin
			wr(3'h0, 32'h188); // seq waits kept nonzero for strobe memories
			for (k = 0; k < 4; k = k + 1)
				wr(3'h4 + k[2:0], 32'h5a00_0000 + k);
			wr(3'h1, 32'h20);
			run(5'h0d);
			chk("cs1", 32'hd, {28'h0, cs_seen});
			chk("strobe", 32'he, wes);
			chk("doe", 32'h0, {31'h0, doe_n});
			for (k = 0; k < 4; k = k + 1)
				chk("mem", 32'h5a00_0000 + k, mdl.mem[8 + k]);
			chk("wdir", 32'h1, {31'h0, dir});
			chk("wdata", 32'h5a00_0003, o_data);
		end
	endtask
	// sequential mode: first read after a write is non-sequential
	task t_seq_read;
		begin
			wr(3'h0, 32'h42);
			wr(3'h1, 32'h14);
			run(5'h04);
			chk("nseqlen", 32'h7, low);
			run(5'h02);
			chk("seqlen", 32'h3, low);
			rd(3'h4, v);
			chk("hdata", 32'hc0de_0005, v);
			chk("hwidth", 32'h2, {30'h0, hw, wd});
			chk("rdoe", 32'h1, {31'h0, doe_n});
		end
	endtask
	// ----
	// clock, watchdog, main sequence
	// ----
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// ceiling well above the couple of hundred cycles the tests need
	always @(posedge i_mclk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_sim;
		end
	end
	initial begin
		err_total = 0;
		cmp_count = 0;
		cyc = 0;
		slow = 1'b0;
		i_nrst = 1'b0;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		i_reg_addr = 3'h0;
		i_reg_wdata = 32'h0;
		repeat (5) @(posedge i_mclk);
		i_nrst <= 1'b1;
		t_reset;
		t_single_read;
		t_burst_read;
		t_burst_write;
		t_seq_read;
		end_sim;
	end
endmodule // test_smem_port
